// ---- inc/psl_map.svh ----
// register offsets, field positions, reset values and counts of the strap latch
`ifndef PSL_MAP_SVH
`define PSL_MAP_SVH

`define PSL_STATUS_OFS      12'h000
`define PSL_CONTROL_OFS     12'h004

`define PSL_CTRL_CONT_BIT   0

`define PSL_ST_PG_LSB       0
`define PSL_ST_RST_LSB      8
`define PSL_ST_STATE_LSB    10
`define PSL_ST_DONE_BIT     14

`define PSL_RG_TRISTATE     0
`define PSL_RG_SELF_TEST    1

`define PSL_PG_SVC_BOOT     0
`define PSL_PG_TRUST_PLAT   1
`define PSL_PG_HALT         2
`define PSL_PG_FW_AGENT     3
`define PSL_PG_TRUST_AGENT  4
`define PSL_PG_SAFE_MODE    5
`define PSL_PG_SOCKET_LSB   6

`define PSL_RG_RESET        2'h0
`define PSL_PG_RESET        8'h00
`define PSL_PRDATA_RESET    32'h0000_0000

`define PSL_SELF_TEST_CYCLES 64

`endif

// ---- inc/psl_pkg.sv ----
// types shared by the strap latch design
package psl_pkg;

    typedef enum logic [3:0] {
        PSL_IDLE     = 4'h1,
        PSL_SELFTEST = 4'h2,
        PSL_HALT     = 4'h4,
        PSL_RUN      = 4'h8
    } psl_state_e;

    typedef logic [1:0] psl_rg_t;
    typedef logic [7:0] psl_pg_t;

endpackage

// ---- core/psl_capture.sv ----
// edge-triggered capture register for one group of straps
`timescale 1ns/10ps
module psl_capture #(
    parameter int          WIDTH     = 8,
    parameter logic [WIDTH-1:0] RESET_VAL = '0
) (
    input  wire logic             pclk,
    input  wire logic             presetn,
    input  wire logic             trigger,
    input  wire logic [WIDTH-1:0] d,
    output logic      [WIDTH-1:0] q_ff
);

    logic [WIDTH-1:0] nxt_q;

    // hold unless the own latching edge arrives
    always_comb begin
        nxt_q = q_ff;
        if (trigger) begin
            nxt_q = d;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            q_ff <= RESET_VAL;
        end else begin
            q_ff <= nxt_q;
        end
    end

endmodule // psl_capture

// ---- core/psl_strap_latch.sv ----
// power-on strap latch with power-up sequencer and apb status/control
`timescale 1ns/10ps
`include "psl_map.svh"
module psl_strap_latch
    import psl_pkg::*;
#(
    parameter int SELF_TEST_CYCLES = `PSL_SELF_TEST_CYCLES
) (
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [11:0] paddr,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    input  wire logic        reset_l,
    input  wire logic        power_good_in,
    input  wire logic        thermal_hot_l,
    input  wire logic        self_test_request,
    input  wire logic        service_processor_boot,
    input  wire logic        trusted_platform_enable,
    input  wire logic        powerup_halt_l,
    input  wire logic        firmware_agent_enable,
    input  wire logic        trusted_agent_enable,
    input  wire logic        safe_mode_boot,
    input  wire logic [1:0]  socket_number,
    output logic             output_tristate,
    output logic             self_test_active,
    output logic             self_test_done,
    output logic             powerup_halted,
    output logic             boot_running,
    output logic             safe_mode_active,
    output logic             service_processor_mode,
    output logic             trusted_platform_mode,
    output logic             firmware_agent_mode,
    output logic             trusted_agent_mode,
    output logic [1:0]       socket_id
);

    localparam int CNT_W = $clog2(SELF_TEST_CYCLES + 1);

    // edge detection state
    logic           rst_prev_ff;
    logic           pg_prev_ff;
    logic           nxt_rst_prev;
    logic           nxt_pg_prev;
    logic           rst_rise;
    logic           pg_rise;

    // latched strap groups
    psl_rg_t        rg_d;
    psl_rg_t        rg_ff;
    psl_pg_t        pg_d;
    psl_pg_t        pg_ff;

    // sequencer state
    psl_state_e     state_ff;
    psl_state_e     nxt_state;
    logic [CNT_W-1:0] cnt_ff;
    logic [CNT_W-1:0] nxt_cnt;
    logic           done_ff;
    logic           nxt_done;
    logic           safe_ff;
    logic           nxt_safe;

    // apb state
    logic [31:0]    prdata_ff;
    logic [31:0]    nxt_prdata;
    logic [31:0]    status_word;
    logic           hit_status;
    logic           hit_control;
    logic           access;
    logic           cont_pulse;

    assign nxt_rst_prev = reset_l;
    assign nxt_pg_prev  = power_good_in;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            rst_prev_ff <= 1'b0;
            pg_prev_ff  <= 1'b0;
        end else begin
            rst_prev_ff <= nxt_rst_prev;
            pg_prev_ff  <= nxt_pg_prev;
        end
    end

    assign rst_rise = reset_l & ~rst_prev_ff;
    assign pg_rise  = power_good_in & ~pg_prev_ff;

    always_comb begin
        rg_d = `PSL_RG_RESET;
        rg_d[`PSL_RG_TRISTATE]  = ~thermal_hot_l;
        rg_d[`PSL_RG_SELF_TEST] = self_test_request;
    end

    always_comb begin
        pg_d = `PSL_PG_RESET;
        pg_d[`PSL_PG_SVC_BOOT]    = service_processor_boot;
        pg_d[`PSL_PG_TRUST_PLAT]  = trusted_platform_enable;
        pg_d[`PSL_PG_HALT]        = ~powerup_halt_l;
        pg_d[`PSL_PG_FW_AGENT]    = firmware_agent_enable;
        pg_d[`PSL_PG_TRUST_AGENT] = trusted_agent_enable;
        pg_d[`PSL_PG_SAFE_MODE]   = safe_mode_boot;
        pg_d[`PSL_PG_SOCKET_LSB +: 2] = socket_number;
    end

    psl_capture #(
        .WIDTH     ($bits(psl_rg_t)),
        .RESET_VAL (`PSL_RG_RESET)
    ) u_rst_group (
        .pclk    (pclk),
        .presetn (presetn),
        .trigger (rst_rise),
        .d       (rg_d),
        .q_ff    (rg_ff)
    );

    psl_capture #(
        .WIDTH     ($bits(psl_pg_t)),
        .RESET_VAL (`PSL_PG_RESET)
    ) u_pg_group (
        .pclk    (pclk),
        .presetn (presetn),
        .trigger (pg_rise),
        .d       (pg_d),
        .q_ff    (pg_ff)
    );

    // power-up sequencer
    always_comb begin
        nxt_state = state_ff;
        nxt_cnt   = cnt_ff;
        nxt_done  = done_ff;
        case (state_ff)
            PSL_IDLE: begin
                if (rst_rise) begin
                    nxt_done = 1'b0;
                    if (self_test_request) begin
                        nxt_state = PSL_SELFTEST;
                        nxt_cnt   = CNT_W'(SELF_TEST_CYCLES - 1);
                    end else if (pg_ff[`PSL_PG_HALT]) begin
                        nxt_state = PSL_HALT;
                    end else begin
                        nxt_state = PSL_RUN;
                    end
                end
            end
            PSL_SELFTEST: begin
                if (cnt_ff == '0) begin
                    nxt_done = 1'b1;
                    if (pg_ff[`PSL_PG_HALT]) begin
                        nxt_state = PSL_HALT;
                    end else begin
                        nxt_state = PSL_RUN;
                    end
                end else begin
                    nxt_cnt = cnt_ff - CNT_W'(1);
                end
            end
            PSL_HALT: begin
                if (cont_pulse) begin
                    nxt_state = PSL_RUN;
                end
            end
            PSL_RUN: begin
                nxt_state = PSL_RUN;
            end
            default: begin
                nxt_state = PSL_IDLE;
            end
        endcase
        if (!reset_l) begin
            nxt_state = PSL_IDLE;
            nxt_cnt   = '0;
        end
    end

    assign nxt_safe = (nxt_state == PSL_RUN) & pg_ff[`PSL_PG_SAFE_MODE];

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state_ff <= PSL_IDLE;
            cnt_ff   <= '0;
            done_ff  <= 1'b0;
            safe_ff  <= 1'b0;
        end else begin
            state_ff <= nxt_state;
            cnt_ff   <= nxt_cnt;
            done_ff  <= nxt_done;
            safe_ff  <= nxt_safe;
        end
    end

    assign output_tristate        = rg_ff[`PSL_RG_TRISTATE];
    assign self_test_active       = (state_ff == PSL_SELFTEST);
    assign powerup_halted         = (state_ff == PSL_HALT);
    assign boot_running           = (state_ff == PSL_RUN);
    assign self_test_done         = done_ff;
    assign safe_mode_active       = safe_ff;
    assign service_processor_mode = pg_ff[`PSL_PG_SVC_BOOT];
    assign trusted_platform_mode  = pg_ff[`PSL_PG_TRUST_PLAT];
    assign firmware_agent_mode    = pg_ff[`PSL_PG_FW_AGENT];
    assign trusted_agent_mode     = pg_ff[`PSL_PG_TRUST_AGENT];
    assign socket_id              = pg_ff[`PSL_PG_SOCKET_LSB +: 2];

    // apb slave, zero wait states
    assign hit_status  = (paddr == `PSL_STATUS_OFS);
    assign hit_control = (paddr == `PSL_CONTROL_OFS);
    assign access      = psel & penable;
    assign pready      = 1'b1;
    assign pslverr     = access & ~(hit_control | (hit_status & ~pwrite));
    assign cont_pulse  = access & pwrite & hit_control & pwdata[`PSL_CTRL_CONT_BIT];

    always_comb begin
        status_word = `PSL_PRDATA_RESET;
        status_word[`PSL_ST_PG_LSB +: 8]    = pg_ff;
        status_word[`PSL_ST_RST_LSB +: 2]   = rg_ff;
        status_word[`PSL_ST_STATE_LSB +: 4] = state_ff;
        status_word[`PSL_ST_DONE_BIT]       = done_ff;
    end

    // read data captured in the setup cycle
    always_comb begin
        nxt_prdata = prdata_ff;
        if (psel & ~penable & ~pwrite) begin
            nxt_prdata = hit_status ? status_word : `PSL_PRDATA_RESET;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata_ff <= `PSL_PRDATA_RESET;
        end else begin
            prdata_ff <= nxt_prdata;
        end
    end

    assign prdata = prdata_ff;

    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    reset_capture_a: assert property (rst_rise |=> rg_ff == $past(rg_d))
        else $error("reset group not captured at reset release");

    rg_hold_a: assert property (!rst_rise |=> $stable(rg_ff))
        else $error("reset group changed without reset release");

    tristate_mode_a: assert property (rst_rise && !thermal_hot_l |=> output_tristate [*2])
        else $error("tri-state mode not entered");

    self_test_start_a: assert property (state_ff == PSL_IDLE && rst_rise && self_test_request
        |=> self_test_active && !self_test_done)
        else $error("self test did not start");

    pg_capture_a: assert property (pg_rise |=> pg_ff == $past(pg_d) && socket_id == $past(socket_number))
        else $error("power-good group not captured");

    halt_hold_a: assert property (powerup_halted && !cont_pulse && reset_l |=> powerup_halted)
        else $error("left halt without release");

    safe_boot_a: assert property (boot_running && reset_l
        |=> safe_mode_active == $past(pg_ff[`PSL_PG_SAFE_MODE]))
        else $error("safe mode does not follow strap");

    survive_reset_a: assert property ($fell(reset_l) && !pg_rise |=> pg_ff == $past(pg_ff))
        else $error("system reset disturbed latched options");

    read_latency_a: assert property (psel && !penable && !pwrite && hit_status
        ##1 access |-> prdata == $past(status_word))
        else $error("status read data wrong");

    selftest_path_c: cover property (self_test_active ##[1:200] self_test_done);
    halt_release_c: cover property (powerup_halted ##[1:50] boot_running);
    safe_run_c: cover property (boot_running && safe_mode_active && socket_id != 2'h0);

endmodule // psl_strap_latch

// ---- tb/psl_platform_model.sv ----
// platform reset logic and board strap pins facing the strap latch
`timescale 1ns/10ps
module psl_platform_model (
    input  wire logic       pclk,
    input  wire logic       pg_req,
    input  wire logic       rst_req,
    input  wire logic [7:0] pg_st,
    input  wire logic [1:0] rg_st,
    output logic            reset_l                 = 1'b0,
    output logic            power_good_in           = 1'b0,
    output logic            thermal_hot_l           = 1'b1,
    output logic            self_test_request       = 1'b1,
    output logic            service_processor_boot  = 1'b0,
    output logic            trusted_platform_enable = 1'b1,
    output logic            powerup_halt_l          = 1'b1,
    output logic            firmware_agent_enable   = 1'b0,
    output logic            trusted_agent_enable    = 1'b0,
    output logic            safe_mode_boot          = 1'b0,
    output logic [1:0]      socket_number           = 2'h0
);
    always @(posedge pclk) begin
        if (power_good_in == pg_req && reset_l == rst_req) begin
            service_processor_boot  <= pg_st[0];
            trusted_platform_enable <= pg_st[1];
            powerup_halt_l          <= ~pg_st[2];
            firmware_agent_enable   <= pg_st[3];
            trusted_agent_enable    <= pg_st[4];
            safe_mode_boot          <= pg_st[5];
            socket_number           <= pg_st[7:6];
            thermal_hot_l           <= ~rg_st[0];
            self_test_request       <= rg_st[1];
        end
        power_good_in <= pg_req;
        reset_l       <= rst_req;
    end
endmodule // psl_platform_model

// ---- tb/psl_strap_latch_bench.sv ----
// self-checking bench for the strap latch with apb status reads
`timescale 1ns/10ps
`include "psl_map.svh"
module psl_strap_latch_bench
    import psl_pkg::*;
;
    localparam int STC = 4;
    typedef struct {logic [32:0] v; logic [32:0] m;} psl_exp_s;
    psl_exp_s     q[$];
    psl_exp_s     e;
    logic         pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [11:0]  paddr = 12'h000;
    logic [31:0]  pwdata = 32'h0, prdata;
    logic         pready, pslverr, pg_req = 1'b0, rst_req = 1'b0;
    logic [7:0]   pg_st = 8'h00, pgv;
    logic [1:0]   rg_st = 2'h0, rgv, sock, o_sock;
    logic         rl, pg, th, st, sp, tp, hl, fa, ta, sm;
    logic         o_ts, o_sta, o_std, o_hlt, o_run, o_safe, o_sp, o_tp, o_fa, o_ta;
    logic [3:0]   sv;
    int           errors = 0, checked = 0, i;
    integer       seed = 32'h1AFADCF4;

    psl_strap_latch #(.SELF_TEST_CYCLES(STC)) dut (.pclk(pclk), .presetn(presetn), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .reset_l(rl), .power_good_in(pg), .thermal_hot_l(th),
        .self_test_request(st), .service_processor_boot(sp), .trusted_platform_enable(tp),
        .powerup_halt_l(hl), .firmware_agent_enable(fa), .trusted_agent_enable(ta),
        .safe_mode_boot(sm), .socket_number(sock), .output_tristate(o_ts), .self_test_active(o_sta),
        .self_test_done(o_std), .powerup_halted(o_hlt), .boot_running(o_run),
        .safe_mode_active(o_safe), .service_processor_mode(o_sp), .trusted_platform_mode(o_tp),
        .firmware_agent_mode(o_fa), .trusted_agent_mode(o_ta), .socket_id(o_sock));
    psl_platform_model plat (.pclk(pclk), .pg_req(pg_req), .rst_req(rst_req), .pg_st(pg_st),
        .rg_st(rg_st), .reset_l(rl), .power_good_in(pg), .thermal_hot_l(th), .self_test_request(st),
        .service_processor_boot(sp), .trusted_platform_enable(tp), .powerup_halt_l(hl),
        .firmware_agent_enable(fa), .trusted_agent_enable(ta), .safe_mode_boot(sm),
        .socket_number(sock));

    initial begin
        forever #5 pclk = ~pclk;
    end

    task automatic summarize();
        $display("errors %0d checked %0d", errors, checked);
        if (errors == 0 && checked > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask

    task automatic chk(string nm, logic [31:0] x, logic [31:0] g);
        checked++;
        if (g !== x) begin
            errors++;
            $display("mismatch %s expected %h seen %h", nm, x, g);
        end
    endtask

    task automatic apb(logic w, logic [11:0] a, logic [31:0] d, logic [32:0] v, logic [32:0] m);
        q.push_back('{v, m});
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        @(posedge pclk);
        while (pready !== 1'b1) begin
            @(posedge pclk);
        end
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask

    function automatic logic [32:0] stat(logic [7:0] p, logic [1:0] r, logic [3:0] s, logic d);
        return {18'h0, d, s, r, p};
    endfunction

    always @(posedge pclk) begin
        if (psel && penable && pready === 1'b1) begin
            if (q.size() > 0) begin
                e = q.pop_front();
            end else begin
                e = '{33'h0, 33'h1_FFFF_FFFF};
            end
            checked++;
            if ((({pslverr, prdata} ^ e.v) & e.m) !== 33'h0) begin
                errors++;
                $display("mismatch apb_%h expected %h seen %h", paddr, e.v, {pslverr, prdata});
            end
        end
    end

    initial begin
        #200000;
        errors++;
        summarize();
    end

    initial begin
        repeat (5) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        apb(1'b0, `PSL_STATUS_OFS, 32'h0, stat(8'h00, 2'h0, PSL_IDLE, 1'b0), 33'h1_FFFF_FFFF);
        apb(1'b0, 12'h008, 32'h0, 33'h1_0000_0000, 33'h1_FFFF_FFFF);
        apb(1'b1, `PSL_STATUS_OFS, 32'h1, 33'h1_0000_0000, 33'h1_0000_0000);
        apb(1'b0, `PSL_CONTROL_OFS, 32'h0, 33'h0, 33'h1_FFFF_FFFF);
        for (i = 0; i < 5; i++) begin
            if (i != 2) begin
                pgv = (i == 0) ? 8'h25 : 8'($random(seed));
                pg_req <= 1'b0;
                repeat (2) @(posedge pclk);
                pg_st <= pgv;
                repeat (2) @(posedge pclk);
                pg_req <= 1'b1;
                repeat (3) @(posedge pclk);
            end
            rgv = (i == 0) ? 2'h3 : 2'($random(seed));
            rst_req <= 1'b0;
            rg_st <= rgv;
            repeat (3) @(posedge pclk);
            rst_req <= 1'b1;
            repeat (4) @(posedge pclk);
            if (rgv[1]) chk("self_test_active", 32'h1, o_sta);
            repeat (STC + 6) @(posedge pclk);
            sv = pgv[2] ? PSL_HALT : PSL_RUN;
            apb(1'b0, `PSL_STATUS_OFS, 32'h0, stat(pgv, rgv, sv, rgv[1]), 33'h1_FFFF_FFFF);
            chk("output_tristate", 32'(rgv[0]), o_ts);
            chk("pg_modes", 32'(pgv[4:0] & 8'h1B), {o_ta, o_fa, 1'b0, o_tp, o_sp});
            chk("socket_id", 32'(pgv[7:6]), o_sock);
            chk("self_test_done", 32'(rgv[1]), o_std);
            if (pgv[2]) begin
                pg_st <= ~pgv;
                rg_st <= ~rgv;
                repeat (3) @(posedge pclk);
                apb(1'b0, `PSL_STATUS_OFS, 32'h0, stat(pgv, rgv, sv, rgv[1]), 33'h1_FFFF_FFFF);
                chk("halted", 32'h1, {o_run, o_hlt});
                apb(1'b1, `PSL_CONTROL_OFS, 32'h1, 33'h0, 33'h1_0000_0000);
                repeat (2) @(posedge pclk);
                apb(1'b0, `PSL_STATUS_OFS, 32'h0, stat(pgv, rgv, PSL_RUN, rgv[1]), 33'h1_FFFF_FFFF);
            end
            chk("boot_running", 32'h1, o_run);
            chk("safe_mode_active", 32'(pgv[5]), o_safe);
        end
        summarize();
    end
endmodule // psl_strap_latch_bench
